// ===== cbwin_config.sv
// Memory and I/O forwarding windows plus interrupt line/pin registers.
// Assumes config accesses and address queries come from logic on clk.
// Functional notes
// - Memory top register is the highest address of each memory window.
// - Memory window bits 31..12 writable, giving 4 KB placement.
// - Memory top bits 11..0 read zero, writes ignored.
// - Memory window claims only if bottom or top is nonzero.
// - Prefetch of each memory window follows its own bridge control bit.
// - I/O bottom and top registers decide I/O forwarding both ways.
// - I/O bottom low half sets offset, high half selects 64 KB page.
// - I/O bottom bits 31..2 writable, bits 1..0 read zero.
// - I/O window enabled only if bottom or top is nonzero.
// - I/O top bits 15..2 writable, bits 1..0 read zero.
// - I/O top bits 31..16 read zero; page comes from I/O bottom.
// - I/O top compare treats its two low bits as ones.
// - Interrupt line is 8-bit read/write, resets to all ones.
// - Interrupt pin value also depends on the signaling mode field.
// - Mode 3 reads 00h; otherwise tied: both functions read 01h; untied: function 0 01h, function 1 02h.
// - Prefetch select bits reset to one; zero makes window nonprefetchable.
`timescale 1ns/1ns
`default_nettype none

module cbwin_config (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic func_id,
  input wire logic irq_functions_tied_bit,
  input wire logic [1:0] irq_signaling_mode_field,
  input wire cbwin_pkg::cbwin_cfg_req_t cfg_req,
  output var cbwin_pkg::cbwin_cfg_rsp_t cfg_rsp,
  input wire cbwin_pkg::cbwin_query_t query,
  output var cbwin_pkg::cbwin_result_t result,
  output logic [1:0] mem_window_prefetchable
);
  import cbwin_pkg::*;

  // ==========================================================
  // Storage
  // ==========================================================
  // Only writable bits are stored; read-only zeros are rebuilt on read
  logic [31:MEM_ADDR_LSB] mem_bot_r [NUM_WINDOWS];
  logic [31:MEM_ADDR_LSB] mem_bot_nxt [NUM_WINDOWS];
  logic [31:MEM_ADDR_LSB] mem_top_r [NUM_WINDOWS];
  logic [31:MEM_ADDR_LSB] mem_top_nxt [NUM_WINDOWS];
  logic [31:IO_ADDR_LSB] io_bot_r [NUM_WINDOWS];
  logic [31:IO_ADDR_LSB] io_bot_nxt [NUM_WINDOWS];
  logic [IO_LIMIT_MSB:IO_ADDR_LSB] io_top_r [NUM_WINDOWS];
  logic [IO_LIMIT_MSB:IO_ADDR_LSB] io_top_nxt [NUM_WINDOWS];
  logic [31:0] mem_bot_word [NUM_WINDOWS];
  logic [31:0] mem_top_word [NUM_WINDOWS];
  logic [31:0] io_bot_word [NUM_WINDOWS];
  logic [31:0] io_top_word [NUM_WINDOWS];
  logic [NUM_WINDOWS-1:0] win_hit;
  logic [7:0] irq_line_r;
  logic [7:0] irq_line_nxt;
  logic [1:0] prefetch_r;
  logic [1:0] prefetch_nxt;
  logic [7:0] irq_pin;
  logic [31:0] word_at_3c;
  cbwin_cfg_rsp_t rsp_nxt;
  cbwin_result_t result_nxt;

  // Byte-lane merge of a write into a full word
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge_be

  // ==========================================================
  // Per-window registers and address match
  // ==========================================================
  for (genvar i = 0; i < NUM_WINDOWS; i++) begin : g_win
    localparam logic [7:0] MB = (i == 0) ? OFS_MEM_WINDOW0_BOTTOM : OFS_MEM_WINDOW1_BOTTOM;
    localparam logic [7:0] MT = (i == 0) ? OFS_MEM_WINDOW0_TOP : OFS_MEM_WINDOW1_TOP;
    localparam logic [7:0] IB = (i == 0) ? OFS_IO_WINDOW0_BOTTOM : OFS_IO_WINDOW1_BOTTOM;
    localparam logic [7:0] IT = (i == 0) ? OFS_IO_WINDOW0_TOP : OFS_IO_WINDOW1_TOP;
    logic [31:0] io_top_full;
    logic mem_en;
    logic io_en;

    // Read views rebuild the hardwired zero bits
    assign mem_bot_word[i] = {mem_bot_r[i], {MEM_ADDR_LSB{1'b0}}};
    assign mem_top_word[i] = {mem_top_r[i], {MEM_ADDR_LSB{1'b0}}};
    assign io_bot_word[i] = {io_bot_r[i], {IO_ADDR_LSB{1'b0}}};
    assign io_top_word[i] = {{(32-IO_PAGE_LSB){1'b0}}, io_top_r[i], {IO_ADDR_LSB{1'b0}}};

    // Next values: a write touches only its writable bits
    always_comb begin
      logic [31:0] m;
      m = 32'h0000_0000;
      mem_bot_nxt[i] = mem_bot_r[i];
      mem_top_nxt[i] = mem_top_r[i];
      io_bot_nxt[i] = io_bot_r[i];
      io_top_nxt[i] = io_top_r[i];
      if (cfg_req.wr) begin
        if (cfg_req.addr == MB) begin
          m = merge_be(mem_bot_word[i], cfg_req.wdata, cfg_req.be);
          mem_bot_nxt[i] = m[31:MEM_ADDR_LSB];
        end
        if (cfg_req.addr == MT) begin
          m = merge_be(mem_top_word[i], cfg_req.wdata, cfg_req.be);
          mem_top_nxt[i] = m[31:MEM_ADDR_LSB];
        end
        if (cfg_req.addr == IB) begin
          m = merge_be(io_bot_word[i], cfg_req.wdata, cfg_req.be);
          io_bot_nxt[i] = m[31:IO_ADDR_LSB];
        end
        if (cfg_req.addr == IT) begin
          m = merge_be(io_top_word[i], cfg_req.wdata, cfg_req.be);
          io_top_nxt[i] = m[IO_LIMIT_MSB:IO_ADDR_LSB];
        end
      end
    end

    // Window registers, all zero so every window starts disabled
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_bot_r[i] <= '0;
        mem_top_r[i] <= '0;
        io_bot_r[i] <= '0;
        io_top_r[i] <= '0;
      end else if (ce) begin
        mem_bot_r[i] <= mem_bot_nxt[i];
        mem_top_r[i] <= mem_top_nxt[i];
        io_bot_r[i] <= io_bot_nxt[i];
        io_top_r[i] <= io_top_nxt[i];
      end
    end

    // I/O top borrows the page of the bottom register
    assign io_top_full = {io_bot_r[i][31:IO_PAGE_LSB], io_top_r[i], 2'b11};
    assign mem_en = (mem_bot_r[i] != '0) || (mem_top_r[i] != '0);
    assign io_en = (io_bot_r[i] != '0) || (io_top_r[i] != '0);

    // Inclusive range compare; low limit bits count as ones
    always_comb begin
      if (query.is_io) begin
        win_hit[i] = io_en && (query.addr >= io_bot_word[i])
                     && (query.addr <= io_top_full);
      end else begin
        win_hit[i] = mem_en && (query.addr >= mem_bot_word[i])
                     && (query.addr <= {mem_top_r[i], {MEM_ADDR_LSB{1'b1}}});
      end
    end
  end

  // ==========================================================
  // Interrupt pin value
  // ==========================================================
  // Reserved mode reports no pin so software does not route a dead line
  always_comb begin
    if (irq_signaling_mode_field == IRQ_MODE_RESERVED) begin
      irq_pin = IRQ_PIN_NONE;
    end else if (irq_functions_tied_bit || !func_id) begin
      irq_pin = IRQ_PIN_INTA;
    end else begin
      irq_pin = IRQ_PIN_INTB;
    end
  end

  // ==========================================================
  // Interrupt line and prefetch select
  // ==========================================================
  // Bridge control byte 3 carries only the two prefetch selects; all else reads zero
  assign word_at_3c = {6'h00, prefetch_r, 8'h00, irq_pin, irq_line_r};

  // Shared dword: line, pin (read-only), bridge control prefetch bits
  always_comb begin
    logic [31:0] m;
    m = merge_be(word_at_3c, cfg_req.wdata, cfg_req.be);
    irq_line_nxt = irq_line_r;
    prefetch_nxt = prefetch_r;
    if (cfg_req.wr && cfg_req.addr == OFS_IRQ_ROUTING_LINE) begin
      irq_line_nxt = m[LINE_LSB +: 8];
      prefetch_nxt = {m[BCTL_LSB + MEM_WINDOW1_PREFETCHABLE_BIT], m[BCTL_LSB + MEM_WINDOW0_PREFETCHABLE_BIT]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_line_r <= IRQ_LINE_RESET;
      prefetch_r <= {PREFETCH_RESET, PREFETCH_RESET};
    end else if (ce) begin
      irq_line_r <= irq_line_nxt;
      prefetch_r <= prefetch_nxt;
    end
  end

  // ==========================================================
  // Configuration read answer
  // ==========================================================
  // Unmapped offsets read as zero; answer one cycle after the request
  always_comb begin
    rsp_nxt.valid = cfg_req.rd || cfg_req.wr;
    rsp_nxt.rdata_valid = cfg_req.rd;
    rsp_nxt.rdata = 32'h0000_0000;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        OFS_MEM_WINDOW0_BOTTOM: rsp_nxt.rdata = mem_bot_word[0];
        OFS_MEM_WINDOW0_TOP: rsp_nxt.rdata = mem_top_word[0];
        OFS_MEM_WINDOW1_BOTTOM: rsp_nxt.rdata = mem_bot_word[1];
        OFS_MEM_WINDOW1_TOP: rsp_nxt.rdata = mem_top_word[1];
        OFS_IO_WINDOW0_BOTTOM: rsp_nxt.rdata = io_bot_word[0];
        OFS_IO_WINDOW0_TOP: rsp_nxt.rdata = io_top_word[0];
        OFS_IO_WINDOW1_BOTTOM: rsp_nxt.rdata = io_bot_word[1];
        OFS_IO_WINDOW1_TOP: rsp_nxt.rdata = io_top_word[1];
        OFS_IRQ_ROUTING_LINE: rsp_nxt.rdata = word_at_3c;
        default: rsp_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Window decision
  // ==========================================================
  // CardBus-side cycles go upstream only when no window claims them
  always_comb begin
    result_nxt.valid = query.valid;
    result_nxt.hit = query.valid ? win_hit : 2'b00;
    result_nxt.forward = query.valid && (query.from_cardbus ? (win_hit == 2'b00) : (win_hit != 2'b00));
    // Window 0 wins the prefetch answer if both overlap
    if (!query.valid || query.is_io) begin
      result_nxt.prefetchable = 1'b0;
    end else if (win_hit[0]) begin
      result_nxt.prefetchable = prefetch_r[0];
    end else begin
      result_nxt.prefetchable = win_hit[1] && prefetch_r[1];
    end
  end

  // Output flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rsp <= '0;
      result <= '0;
      mem_window_prefetchable <= {PREFETCH_RESET, PREFETCH_RESET};
    end else if (ce) begin
      cfg_rsp <= rsp_nxt;
      result <= result_nxt;
      mem_window_prefetchable <= prefetch_nxt;
    end
  end

endmodule : cbwin_config

`default_nettype wire

// ===== cbwin_pkg.sv
// Package for the bridge window and interrupt configuration block.
// Assumes one configuration access port on the 125 MHz clock.
package cbwin_pkg;

  // ==========================================================
  // Register offsets (byte addresses in configuration space)
  // ==========================================================
  localparam logic [7:0] OFS_MEM_WINDOW0_BOTTOM = 8'h1C;
  localparam logic [7:0] OFS_MEM_WINDOW0_TOP = 8'h20;
  localparam logic [7:0] OFS_MEM_WINDOW1_BOTTOM = 8'h24;
  localparam logic [7:0] OFS_MEM_WINDOW1_TOP = 8'h28;
  localparam logic [7:0] OFS_IO_WINDOW0_BOTTOM = 8'h2C;
  localparam logic [7:0] OFS_IO_WINDOW0_TOP = 8'h30;
  localparam logic [7:0] OFS_IO_WINDOW1_BOTTOM = 8'h34;
  localparam logic [7:0] OFS_IO_WINDOW1_TOP = 8'h38;
  localparam logic [7:0] OFS_IRQ_ROUTING_LINE = 8'h3C;
  localparam logic [7:0] OFS_IRQ_PIN_SELECT = 8'h3D;
  localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3E;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int MEM_ADDR_LSB = 12;
  localparam int IO_ADDR_LSB = 2;
  localparam int IO_PAGE_LSB = 16;
  localparam int IO_LIMIT_MSB = 15;
  localparam int LINE_LSB = 0;
  localparam int PIN_LSB = 8;
  localparam int BCTL_LSB = 16;
  localparam int MEM_WINDOW0_PREFETCHABLE_BIT = 8;
  localparam int MEM_WINDOW1_PREFETCHABLE_BIT = 9;
  localparam int NUM_WINDOWS = 2;

  // ==========================================================
  // Reset and fixed values
  // ==========================================================
  localparam logic [7:0] IRQ_LINE_RESET = 8'hFF;
  localparam logic PREFETCH_RESET = 1'b1;
  localparam logic [7:0] IRQ_PIN_INTA = 8'h01;
  localparam logic [7:0] IRQ_PIN_INTB = 8'h02;
  localparam logic [7:0] IRQ_PIN_NONE = 8'h00;
  localparam logic [1:0] IRQ_MODE_RESERVED = 2'h3;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbwin_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic rdata_valid;
    logic [31:0] rdata;
  } cbwin_cfg_rsp_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic from_cardbus;
    logic [31:0] addr;
  } cbwin_query_t;

  typedef struct packed {
    logic valid;
    logic forward;
    logic [1:0] hit;
    logic prefetchable;
  } cbwin_result_t;

endpackage : cbwin_pkg

// ===== cbwin_config_properties.sv
// Port checker for the window and interrupt config block.
// Assumes a single clk domain; attached by bind below.
`timescale 1ns/1ns
`default_nettype none
module cbwin_config_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic func_id,
  input wire logic irq_functions_tied_bit,
  input wire logic [1:0] irq_signaling_mode_field,
  input wire cbwin_pkg::cbwin_cfg_req_t cfg_req,
  input wire cbwin_pkg::cbwin_cfg_rsp_t cfg_rsp,
  input wire cbwin_pkg::cbwin_query_t query,
  input wire cbwin_pkg::cbwin_result_t result,
  input wire logic [1:0] mem_window_prefetchable
);
  import cbwin_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Accepted reads and reads of the interrupt dword
  sequence s_rd;
    ce && cfg_req.rd;
  endsequence
  sequence s_pin_rd;
    s_rd ##0 (cfg_req.addr == OFS_IRQ_ROUTING_LINE);
  endsequence
  // Mode 3 is checked apart, so the tie table excludes it
  sequence s_pin_mode_ok;
    s_pin_rd ##0 (irq_signaling_mode_field != IRQ_MODE_RESERVED);
  endsequence
  // ==========================================
  // Read masks and interrupt pin table
  a_memtop_low_zero: assert property (s_rd ##0 (cfg_req.addr inside {8'h20, 8'h28}) |=>
    cfg_rsp.rdata[11:0] == 12'h000) else $error("memory top low bits not zero");
  a_iobot_dw_align: assert property (s_rd ##0 (cfg_req.addr inside {8'h2C, 8'h34}) |=>
    cfg_rsp.rdata[1:0] == 2'h0) else $error("io bottom low bits not zero");
  a_iotop_page_zero: assert property (s_rd ##0 (cfg_req.addr inside {8'h30, 8'h38}) |=>
    cfg_rsp.rdata[31:16] == 16'h0000 && cfg_rsp.rdata[1:0] == 2'h0) else $error("io top masked bits set");
  a_pin_tied_inta: assert property (s_pin_mode_ok ##0 irq_functions_tied_bit |=>
    cfg_rsp.rdata[15:8] == IRQ_PIN_INTA) else $error("tied pin not INTA");
  a_pin_func_split: assert property (s_pin_mode_ok ##0 !irq_functions_tied_bit |=>
    cfg_rsp.rdata[15:8] == ($past(func_id) ? IRQ_PIN_INTB : IRQ_PIN_INTA)) else $error("untied pin wrong");
  a_pin_mode_none: assert property (s_pin_rd ##0 (irq_signaling_mode_field == IRQ_MODE_RESERVED) |=>
    cfg_rsp.rdata[15:8] == IRQ_PIN_NONE) else $error("pin not zero in mode 3");
  a_pref_mirror: assert property (s_pin_rd |=>
    cfg_rsp.rdata[25:24] == mem_window_prefetchable) else $error("prefetch bits and output differ");
  // ==========================================
  // Forwarding decisions
  a_pci_forward: assert property (ce && query.valid && !query.from_cardbus |=>
    result.valid && result.forward == (result.hit != 2'h0)) else $error("downstream forward wrong");
  a_cb_forward: assert property (ce && query.valid && query.from_cardbus |=>
    result.valid && result.forward == (result.hit == 2'h0)) else $error("upstream forward wrong");
  a_io_no_pref: assert property (ce && query.valid && query.is_io |=>
    !result.prefetchable) else $error("io hit marked prefetchable");
endmodule : cbwin_config_properties

bind cbwin_config cbwin_config_properties u_props (.clk(clk), .arst_n(arst_n), .ce(ce), .func_id(func_id),
  .irq_functions_tied_bit(irq_functions_tied_bit), .irq_signaling_mode_field(irq_signaling_mode_field),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .query(query), .result(result),
  .mem_window_prefetchable(mem_window_prefetchable));
`default_nettype wire

// ===== cbwin_far_agent.sv
// Far-side agent that presents address phases for window lookup.
// Assumes the block samples the query on every rising clk edge.
`timescale 1ns/1ns
`default_nettype none
module cbwin_far_agent (
  input wire logic clk,
  output var cbwin_pkg::cbwin_query_t query
);
  import cbwin_pkg::*;
  initial query = '0;
  // ==========================================
  // One address phase, then the lines let go
  task automatic send(input logic io, input logic cb, input logic [31:0] a);
    @(posedge clk);
    query <= '{valid: 1'b1, is_io: io, from_cardbus: cb, addr: a};
    @(posedge clk);
    // Released lines show the inverse, never a stale copy
    query <= '{valid: 1'b0, is_io: ~io, from_cardbus: ~cb, addr: ~a};
  endtask : send
endmodule : cbwin_far_agent
`default_nettype wire

// ===== tb_cbwin_config.sv
// Self-checking bench for the window and interrupt config block.
// Assumes the far agent and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_cbwin_config;
  import cbwin_pkg::*;
  logic clk, arst_n, func_id, tied, ce;
  logic [1:0] mode, pref;
  cbwin_cfg_req_t req;
  cbwin_cfg_rsp_t rsp;
  cbwin_query_t query;
  cbwin_result_t result;
  int err_total, checks_done;
  logic [31:0] mask [8] = '{32'hFFFFF000, 32'hFFFFF000, 32'hFFFFF000, 32'hFFFFF000,
    32'hFFFFFFFC, 32'h0000FFFC, 32'hFFFFFFFC, 32'h0000FFFC};
  logic [31:0] win [8] = '{32'h10000000, 32'h10001000, 32'h20000000, 32'h20000000,
    32'h00030100, 32'h000001F0, 32'h0, 32'h0};
  logic [31:0] qa [12] = '{32'h0FFFFFFC, 32'h10000000, 32'h10001FFF, 32'h10002000, 32'h20000FFF,
    32'h20001000, 32'h000301F3, 32'h000301F4, 32'h00020100, 32'h00030100, 32'h10000000, 32'h000300FC};
  // Kind {io, cardbus} then expected {forward, hit, prefetchable}
  logic [5:0] qk [12] = '{6'h00, 6'h0B, 6'h0B, 6'h00, 6'h0C, 6'h00, 6'h2A, 6'h20, 6'h20, 6'h32, 6'h20, 6'h20};
  // Clock enable is dropped once to show that a write is frozen out
  cbwin_config u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .func_id(func_id),
    .irq_functions_tied_bit(tied), .irq_signaling_mode_field(mode), .cfg_req(req),
    .cfg_rsp(rsp), .query(query), .result(result), .mem_window_prefetchable(pref));
  cbwin_far_agent u_far (.clk(clk), .query(query));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // Access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cfg(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    req <= '{rd: rd, wr: ~rd, addr: a, be: be, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
    chk({30'h0, rsp.valid, rsp.rdata_valid}, {30'h0, 1'b1, rd});
  endtask : cfg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b1, a, 4'hF, 32'h0);
    chk(rsp.rdata, exp);
  endtask : rd_chk
  task automatic qry(input logic io, input logic cb, input logic [31:0] a, input logic [3:0] exp);
    u_far.send(io, cb, a);
    #1;
    chk({27'h0, result.valid, result.forward, result.hit, result.prefetchable}, {27'h0, 1'b1, exp});
  endtask : qry
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Hang guard, well beyond the roughly 170 cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ==========================================
  // Test sequence
  initial begin
    arst_n = 1'b0;
    func_id = 1'b0;
    tied = 1'b0;
    mode = 2'h0;
    ce = 1'b1;
    req = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(8'h1C + 8'(4 * i), 32'h0);
    rd_chk(OFS_IRQ_ROUTING_LINE, 32'h030001FF);
    qry(1'b0, 1'b0, 32'h0, 4'h0);
    qry(1'b1, 1'b0, 32'h0, 4'h0);
    qry(1'b0, 1'b1, 32'h0, 4'h8);
    // All ones shows which bits are writable, then windows are placed
    for (int i = 0; i < 8; i++) begin
      cfg(1'b0, 8'h1C + 8'(4 * i), 4'hF, 32'hFFFFFFFF);
      rd_chk(8'h1C + 8'(4 * i), mask[i]);
      cfg(1'b0, 8'h1C + 8'(4 * i), 4'hF, win[i]);
    end
    cfg(1'b0, OFS_IRQ_ROUTING_LINE, 4'hF, 32'h01FEFE5A);
    rd_chk(OFS_IRQ_ROUTING_LINE, 32'h0100015A);
    chk({30'h0, pref}, 32'h1);
    cfg(1'b0, OFS_IRQ_ROUTING_LINE, 4'h1, 32'hFF000033);
    rd_chk(OFS_IRQ_ROUTING_LINE, 32'h01000133);
    for (int i = 0; i < 12; i++) qry(qk[i][5], qk[i][4], qa[i], qk[i][3:0]);
    // Swap prefetch selects between the two memory windows
    cfg(1'b0, OFS_IRQ_ROUTING_LINE, 4'h8, 32'h02000000);
    qry(1'b0, 1'b0, 32'h10000000, 4'hA);
    qry(1'b0, 1'b0, 32'h20000000, 4'hD);
    chk({30'h0, pref}, 32'h2);
    // Write with clock enable low must leave the line untouched
    @(posedge clk);
    ce <= 1'b0;
    req <= '{rd: 1'b0, wr: 1'b1, addr: OFS_IRQ_ROUTING_LINE, be: 4'h1, wdata: 32'h00000077};
    @(posedge clk);
    req <= '0;
    ce <= 1'b1;
    rd_chk(OFS_IRQ_ROUTING_LINE, 32'h02000133);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {func_id, tied, mode} <= 4'(i);
      cfg(1'b1, OFS_IRQ_ROUTING_LINE, 4'hF, 32'h0);
      chk({24'h0, rsp.rdata[15:8]}, (i % 4 == 3) ? 32'h0 : ((i % 8 >= 4 || i < 8) ? 32'h1 : 32'h2));
    end
    report_and_stop();
  end
endmodule : tb_cbwin_config
`default_nettype wire
